// ### rtl/habr_pkg.sv
package habr_pkg;
	localparam logic [9:0] HABR_ADDR_INT_STATUS = 10'h2d0;
	localparam logic [9:0] HABR_ADDR_DISPLAY = 10'h2d1;
	localparam logic [9:0] HABR_ADDR_CURSOR_LOW = 10'h2d2;
	localparam logic [9:0] HABR_ADDR_CURSOR_HIGH = 10'h2d3;
	localparam logic [9:0] HABR_ADDR_CONTROL = 10'h2d4;
	localparam logic [9:0] HABR_ADDR_KEYSTROKE = 10'h2d5;
	localparam logic [9:0] HABR_ADDR_TERMINAL = 10'h2d6;
	localparam logic [9:0] HABR_ADDR_WINDOW = 10'h2d7;
	localparam logic [9:0] HABR_ADDR_PAGE_LOW = 10'h2d8;
	localparam logic [9:0] HABR_ADDR_PAGE_HIGH = 10'h2d9;
	localparam logic [9:0] HABR_ADDR_PRINTER = 10'h2da;
	localparam logic [9:0] HABR_ADDR_LINK_ENABLE = 10'h220;

	localparam logic [7:0] HABR_RST_INT_STATUS = 8'h10;
	localparam logic [7:0] HABR_RST_DISPLAY = 8'h00;
	localparam logic [7:0] HABR_RST_CONTROL = 8'h80;
	localparam logic [7:0] HABR_RST_WINDOW = 8'hce;
	localparam logic [7:0] HABR_RST_ZERO = 8'h00;
	localparam logic [7:0] HABR_READ_EMPTY = 8'h00;

	localparam int HABR_ST_KEY = 0;
	localparam int HABR_ST_RESET = 1;
	localparam int HABR_ST_DISPLAY = 2;
	localparam int HABR_ST_TERMID = 3;
	localparam int HABR_ST_DONE = 4;
	localparam int HABR_ST_IOADDR = 5;
	localparam int HABR_ST_BUSY = 6;
	localparam int HABR_ST_IRQ = 7;

	localparam int HABR_DS_INHIBIT_CURSOR = 3;
	localparam int HABR_DS_ALARM = 6;
	localparam int HABR_DS_CLICKER = 7;

	localparam int HABR_CT_LINK = 0;
	localparam int HABR_CT_DFM = 1;
	localparam int HABR_CT_PRN = 2;
	localparam int HABR_CT_KEY = 3;
	localparam int HABR_CT_POLLREQ = 4;
	localparam int HABR_CT_CURSOR = 6;
	localparam int HABR_CT_MASK = 7;

	localparam int HABR_PS_ALARM = 5;
	localparam int HABR_PS_DISABLE = 6;
	localparam int HABR_PS_ENABLE = 7;

	localparam int HABR_WIN_OFF = 0;
	localparam int HABR_PAGE_SEL = 11;

	typedef enum logic [1:0] {
		DISPLAY_TERMINAL_MODE,
		PRINTER_MODE,
		DISTRIBUTED_FUNCTION_MODE
	} habr_mode_e;
endpackage : habr_pkg

// ### rtl/habr_register_bank.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Display mode: keystroke acknowledge sets status b0 until host clears it.
// - Printer and distributed mode: start-operation command sets status b0.
// - Any mode: reset command sets status b1 until host clears it.
// - Status b2 set by control load or alarm/clicker, enable/disable, or diagnostic reset.
// - Distributed mode only: read-terminal_identity command sets status b3.
// - Display mode: end of write, clear or insert sets status b4.
// - Display mode: either load-I/O-address command sets status b5.
// - Display mode: b6 set at modify start, cleared when b4 sets.
// - Status b7 follows b0-b5 while unmasked; cleared by host clear or mask.
// - Display register holds line width, step, display, cursor, alarm and clicker bits.
// - Control unit owns display register; any host write clears only alarm b6.
// - Every control-unit load of the display register sets status b2.
// - Cursor registers are read-only views of the buffer address counter bytes.
// - Control b0 enables link; set by host or 220H write, cleared by host/reset.
// - First poll after link enable is answered with power-on-reset complete.
// - Control b1/b2 choose distributed, printer or display mode.
// - Host sets keystroke-available b3; poll-acknowledge or reset command clears it.
// - Printer/distributed: control b4 requests poll; poll-acknowledge clears it.
// - Printer mode: control b6 holds the buffer address counter at zero.
// - Display mode: control b6 with inhibit-cursor suppresses load-address interrupts.
// - Control b7 masks interrupts, set by reset; status bits still set.
// - Control-unit writes set page-change bits; host writes clear bits written one.
// - Window b0 low and b1-b7 matching address 13-19 allow memory access.
module habr_register_bank
	import habr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] ioAddr,
	input wire logic [7:0] ioWriteData,
	input wire logic ioWrite,
	input wire logic ioRead,
	output logic [7:0] ioReadData,
	input wire logic [6:0] memAddrHigh,
	output logic memAccessEnable,
	output logic irq,
	input wire logic evKeyAck,
	input wire logic evStartOp,
	input wire logic evResetCmd,
	input wire logic evDisplayLoad,
	input wire logic [7:0] displayLoadData,
	input wire logic evPollAlarm,
	input wire logic evPollClickerOn,
	input wire logic evPollClickerOff,
	input wire logic evPollEnableOp,
	input wire logic evPollDisableOp,
	input wire logic evDiagReset,
	input wire logic evReadTermId,
	input wire logic evModifyBegin,
	input wire logic evModifyEnd,
	input wire logic evLoadIoAddr,
	input wire logic evPoll,
	input wire logic evPollAck,
	input wire logic evBufferWrite,
	input wire logic [11:0] bufferWriteAddr,
	input wire logic [15:0] bufferAddr,
	output logic linkEnable,
	output habr_mode_e mode,
	output logic porResponsePending,
	output logic keystrokeAvailable,
	output logic pollRequest,
	output logic holdAddrZero,
	output logic [7:0] keystrokeCode,
	output logic [7:0] terminalId,
	output logic [7:0] displayControl
);
	function automatic logic [7:0] clearSet(input logic [7:0] cur, input logic [7:0] clr, input logic [7:0] set);
		clearSet = (cur & ~clr) | set;
	endfunction : clearSet

	function automatic habr_mode_e decodeMode(input logic [7:0] ctl);
		if (ctl[HABR_CT_DFM]) begin
			decodeMode = DISTRIBUTED_FUNCTION_MODE;
		end else if (ctl[HABR_CT_PRN]) begin
			decodeMode = PRINTER_MODE;
		end else begin
			decodeMode = DISPLAY_TERMINAL_MODE;
		end
	endfunction : decodeMode

	// Host pins are asynchronous to clk; every one of them gets two flops first.
	logic [9:0] addrMeta, addrSync;
	logic [7:0] dataMeta, dataSync;
	logic [6:0] memMeta, memSync;
	logic wrMeta, wrSync, wrLast;
	logic rdMeta, rdSync, rdLast;

	always_ff @(posedge clk) begin
		if (rst) begin
			addrMeta <= 10'h000;
			addrSync <= 10'h000;
			dataMeta <= 8'h00;
			dataSync <= 8'h00;
			memMeta <= 7'h00;
			memSync <= 7'h00;
			wrMeta <= 1'b0;
			wrSync <= 1'b0;
			wrLast <= 1'b0;
			rdMeta <= 1'b0;
			rdSync <= 1'b0;
			rdLast <= 1'b0;
		end else begin
			addrMeta <= ioAddr;
			addrSync <= addrMeta;
			dataMeta <= ioWriteData;
			dataSync <= dataMeta;
			memMeta <= memAddrHigh;
			memSync <= memMeta;
			wrMeta <= ioWrite;
			wrSync <= wrMeta;
			wrLast <= wrSync;
			rdMeta <= ioRead;
			rdSync <= rdMeta;
			rdLast <= rdSync;
		end
	end

	// One access per strobe: act on the rising edge of the synchronised strobe.
	logic wrPulse, rdPulse;
	assign wrPulse = wrSync & ~wrLast;
	assign rdPulse = rdSync & ~rdLast;

	logic wrStatus, wrDisplay, wrControl, wrKey, wrTerm, wrWindow, wrPageLow, wrPageHigh, wrPrinter, wrLink;
	always_comb begin
		wrStatus = 1'b0;
		wrDisplay = 1'b0;
		wrControl = 1'b0;
		wrKey = 1'b0;
		wrTerm = 1'b0;
		wrWindow = 1'b0;
		wrPageLow = 1'b0;
		wrPageHigh = 1'b0;
		wrPrinter = 1'b0;
		wrLink = 1'b0;
		if (!wrPulse) begin
			wrStatus = 1'b0;
		end else if (addrSync == HABR_ADDR_INT_STATUS) begin
			wrStatus = 1'b1;
		end else if (addrSync == HABR_ADDR_DISPLAY) begin
			wrDisplay = 1'b1;
		end else if (addrSync == HABR_ADDR_CONTROL) begin
			wrControl = 1'b1;
		end else if (addrSync == HABR_ADDR_KEYSTROKE) begin
			wrKey = 1'b1;
		end else if (addrSync == HABR_ADDR_TERMINAL) begin
			wrTerm = 1'b1;
		end else if (addrSync == HABR_ADDR_WINDOW) begin
			wrWindow = 1'b1;
		end else if (addrSync == HABR_ADDR_PAGE_LOW) begin
			wrPageLow = 1'b1;
		end else if (addrSync == HABR_ADDR_PAGE_HIGH) begin
			wrPageHigh = 1'b1;
		end else if (addrSync == HABR_ADDR_PRINTER) begin
			wrPrinter = 1'b1;
		end else if (addrSync == HABR_ADDR_LINK_ENABLE) begin
			wrLink = 1'b1;
		end
	end

	logic [7:0] intStatus, control, window, pageLow, pageHigh, printerStatus;
	habr_mode_e curMode;
	logic isDisplay, isPrinter, isDistributed;
	assign curMode = decodeMode(control);
	assign isDisplay = curMode == DISPLAY_TERMINAL_MODE;
	assign isPrinter = curMode == PRINTER_MODE;
	assign isDistributed = curMode == DISTRIBUTED_FUNCTION_MODE;

	// While the link is off the control unit gets no response, so every event is dropped.
	logic on;
	assign on = control[HABR_CT_LINK];

	logic pollDisplaySound;
	assign pollDisplaySound = evPollAlarm | evPollClickerOn | evPollClickerOff;

	logic suppressIoAddr;
	assign suppressIoAddr = isDisplay & control[HABR_CT_CURSOR] & displayControl[HABR_DS_INHIBIT_CURSOR];

	logic [7:0] statusSet;
	always_comb begin
		statusSet = 8'h00;
		statusSet[HABR_ST_KEY] = on & ((isDisplay & evKeyAck) | (~isDisplay & evStartOp));
		statusSet[HABR_ST_RESET] = on & evResetCmd;
		statusSet[HABR_ST_DISPLAY] = on & ((isDisplay & (evDisplayLoad | pollDisplaySound))
			| (isPrinter & (evPollEnableOp | evPollDisableOp))
			| (isDistributed & evDiagReset));
		statusSet[HABR_ST_TERMID] = on & isDistributed & evReadTermId;
		statusSet[HABR_ST_DONE] = on & isDisplay & evModifyEnd;
		statusSet[HABR_ST_IOADDR] = on & isDisplay & evLoadIoAddr;
		statusSet[HABR_ST_BUSY] = on & isDisplay & evModifyBegin;
	end

	logic [7:0] statusClear;
	always_comb begin
		statusClear = wrStatus ? dataSync : 8'h00;
		if (on & isDisplay & evModifyEnd) begin
			statusClear[HABR_ST_BUSY] = 1'b1;
		end
		statusClear[HABR_ST_IRQ] = 1'b1;
	end

	logic [7:0] next_intStatus;
	logic [7:0] next_control;
	logic [5:0] irqSources;
	always_comb begin
		next_intStatus = clearSet(intStatus, statusClear, statusSet);
		irqSources = next_intStatus[5:0];
		if (suppressIoAddr) begin
			irqSources[HABR_ST_IOADDR] = 1'b0;
		end
		// Bit 7 is recomputed each cycle, so a host clear or the mask drops it at once.
		next_intStatus[HABR_ST_IRQ] = ~next_control[HABR_CT_MASK] & (|irqSources);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			intStatus <= HABR_RST_INT_STATUS;
		end else begin
			intStatus <= next_intStatus;
		end
	end

	always_comb begin
		next_control = control;
		if (wrControl) begin
			next_control = dataSync;
		end
		if (wrLink) begin
			next_control[HABR_CT_LINK] = 1'b1;
		end
		// A host set in the same cycle as a decoded clear wins, so a fresh request is not lost.
		if (on & (evPollAck | evResetCmd) & ~(wrControl & dataSync[HABR_CT_KEY])) begin
			next_control[HABR_CT_KEY] = 1'b0;
		end
		if (on & evPollAck & ~(wrControl & dataSync[HABR_CT_POLLREQ])) begin
			next_control[HABR_CT_POLLREQ] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			control <= HABR_RST_CONTROL;
		end else begin
			control <= next_control;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			porResponsePending <= 1'b0;
		end else if (next_control[HABR_CT_LINK] & ~control[HABR_CT_LINK]) begin
			porResponsePending <= 1'b1;
		end else if (~on | evPoll) begin
			porResponsePending <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			displayControl <= HABR_RST_DISPLAY;
		end else if (on & isDisplay & evDisplayLoad) begin
			displayControl <= displayLoadData;
		end else begin
			if (wrDisplay) begin
				displayControl[HABR_DS_ALARM] <= 1'b0;
			end
			if (on & isDisplay & evPollAlarm) begin
				displayControl[HABR_DS_ALARM] <= 1'b1;
			end
			if (on & isDisplay & evPollClickerOn) begin
				displayControl[HABR_DS_CLICKER] <= 1'b1;
			end
			if (on & isDisplay & evPollClickerOff) begin
				displayControl[HABR_DS_CLICKER] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			keystrokeCode <= HABR_RST_ZERO;
			terminalId <= HABR_RST_ZERO;
			window <= HABR_RST_WINDOW;
		end else begin
			if (wrKey) begin
				keystrokeCode <= dataSync;
			end
			if (wrTerm) begin
				terminalId <= dataSync;
			end
			if (wrWindow) begin
				window <= dataSync;
			end
		end
	end

	logic [7:0] pageSet;
	always_comb begin
		pageSet = 8'h00;
		pageSet[bufferWriteAddr[10:8]] = on & evBufferWrite;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pageLow <= HABR_RST_ZERO;
			pageHigh <= HABR_RST_ZERO;
		end else begin
			pageLow <= clearSet(pageLow, wrPageLow ? dataSync : 8'h00,
				bufferWriteAddr[HABR_PAGE_SEL] ? 8'h00 : pageSet);
			pageHigh <= clearSet(pageHigh, wrPageHigh ? dataSync : 8'h00,
				bufferWriteAddr[HABR_PAGE_SEL] ? pageSet : 8'h00);
		end
	end

	logic [7:0] printerSet;
	always_comb begin
		printerSet = 8'h00;
		printerSet[HABR_PS_ALARM] = on & isPrinter & evPollAlarm;
		printerSet[HABR_PS_DISABLE] = on & isPrinter & evPollDisableOp;
		printerSet[HABR_PS_ENABLE] = on & isPrinter & (evPollEnableOp | evStartOp);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			printerStatus <= HABR_RST_ZERO;
		end else begin
			printerStatus <= clearSet(printerStatus, wrPrinter ? dataSync : 8'h00, printerSet);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ioReadData <= HABR_READ_EMPTY;
		end else if (rdPulse) begin
			if (addrSync == HABR_ADDR_INT_STATUS) begin
				ioReadData <= intStatus;
			end else if (addrSync == HABR_ADDR_DISPLAY) begin
				ioReadData <= displayControl;
			end else if (addrSync == HABR_ADDR_CURSOR_LOW) begin
				ioReadData <= bufferAddr[7:0];
			end else if (addrSync == HABR_ADDR_CURSOR_HIGH) begin
				ioReadData <= bufferAddr[15:8];
			end else if (addrSync == HABR_ADDR_CONTROL) begin
				ioReadData <= control;
			end else if (addrSync == HABR_ADDR_WINDOW) begin
				ioReadData <= window;
			end else if (addrSync == HABR_ADDR_PAGE_LOW) begin
				ioReadData <= pageLow;
			end else if (addrSync == HABR_ADDR_PAGE_HIGH) begin
				ioReadData <= pageHigh;
			end else if (addrSync == HABR_ADDR_PRINTER) begin
				ioReadData <= printerStatus;
			end else begin
				ioReadData <= HABR_READ_EMPTY;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
			linkEnable <= 1'b0;
			mode <= DISPLAY_TERMINAL_MODE;
			keystrokeAvailable <= 1'b0;
			pollRequest <= 1'b0;
			holdAddrZero <= 1'b0;
			memAccessEnable <= 1'b0;
		end else begin
			irq <= next_intStatus[HABR_ST_IRQ];
			linkEnable <= next_control[HABR_CT_LINK];
			mode <= decodeMode(next_control);
			keystrokeAvailable <= next_control[HABR_CT_KEY] & (decodeMode(next_control) == DISPLAY_TERMINAL_MODE);
			pollRequest <= next_control[HABR_CT_POLLREQ] & (decodeMode(next_control) != DISPLAY_TERMINAL_MODE);
			holdAddrZero <= next_control[HABR_CT_CURSOR] & (decodeMode(next_control) == PRINTER_MODE);
			memAccessEnable <= ~window[HABR_WIN_OFF] & (window[7:1] == memSync);
		end
	end
endmodule : habr_register_bank

// ### sim/habr_bank_props.sv
`timescale 1ns/10ps
module habr_bank_props
	import habr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ioWrite,
	input wire logic irq,
	input wire logic linkEnable,
	input wire habr_mode_e mode,
	input wire logic porResponsePending,
	input wire logic keystrokeAvailable,
	input wire logic pollRequest,
	input wire logic holdAddrZero,
	input wire logic evPoll,
	input wire logic evPollAck,
	input wire logic evResetCmd,
	input wire logic evDisplayLoad,
	input wire logic [7:0] displayLoadData,
	input wire logic [7:0] displayControl
);
	logic [3:0] wrSeen;
	logic quiet;
	// A host write lands cycles after its strobe, so the keystroke, poll-request and display-load checks only trust a bus that stayed quiet.
	always_ff @(posedge clk) begin
		wrSeen <= {wrSeen[2:0], ioWrite};
	end
	assign quiet = (wrSeen == 4'h0) && !ioWrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_key_clr; quiet && linkEnable && (evPollAck || evResetCmd) |=> !keystrokeAvailable; endproperty
	a_key_clr: assert property (p_key_clr) else $error("keystroke flag kept");
	property p_req_clr; quiet && linkEnable && evPollAck |=> !pollRequest; endproperty
	a_req_clr: assert property (p_req_clr) else $error("poll request kept");
	property p_hold; holdAddrZero |-> mode == PRINTER_MODE; endproperty
	a_hold: assert property (p_hold) else $error("hold outside printer mode");
	property p_link_fall; $fell(linkEnable) |-> wrSeen != 4'h0 || ioWrite || $past(rst); endproperty
	a_link_fall: assert property (p_link_fall) else $error("link dropped by itself");
	property p_por_rise; $rose(linkEnable) |-> ##[0:1] porResponsePending; endproperty
	a_por_rise: assert property (p_por_rise) else $error("no reset response pending");
	property p_por_clr; porResponsePending && linkEnable && evPoll |=> !porResponsePending; endproperty
	a_por_clr: assert property (p_por_clr) else $error("reset response kept");
	property p_load;
		quiet && linkEnable && mode == DISPLAY_TERMINAL_MODE && evDisplayLoad |=> displayControl == $past(displayLoadData);
	endproperty
	a_load: assert property (p_load) else $error("display load lost");
	property p_off; quiet && !linkEnable && evDisplayLoad |=> $stable(displayControl); endproperty
	a_off: assert property (p_off) else $error("load taken with link off");
	property p_irq_fall; $fell(irq) |-> wrSeen != 4'h0 || ioWrite || $past(rst); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
	c_key: cover property (linkEnable && evPollAck && keystrokeAvailable);
	c_por: cover property (porResponsePending && evPoll);
	c_irq: cover property ($rose(irq));
endmodule : habr_bank_props
bind habr_register_bank habr_bank_props u_habr_bank_props (.clk(clk), .rst(rst), .ioWrite(ioWrite), .irq(irq),
	.linkEnable(linkEnable), .mode(mode), .porResponsePending(porResponsePending),
	.keystrokeAvailable(keystrokeAvailable), .pollRequest(pollRequest), .holdAddrZero(holdAddrZero),
	.evPoll(evPoll), .evPollAck(evPollAck), .evResetCmd(evResetCmd), .evDisplayLoad(evDisplayLoad),
	.displayLoadData(displayLoadData), .displayControl(displayControl));

// ### sim/habr_host_model.sv
`timescale 1ns/10ps
module habr_host_model (
	input wire logic clk,
	input wire logic [7:0] ioReadData,
	output logic [9:0] ioAddr,
	output logic [7:0] ioWriteData,
	output logic ioWrite,
	output logic ioRead
);
	initial begin
		ioAddr = 10'h000;
		ioWriteData = 8'h00;
		ioWrite = 1'b0;
		ioRead = 1'b0;
	end
	// Address and data settle three cycles before the strobe since the bank sees them through synchronisers.
	task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk) #1;
		ioAddr = a;
		ioWriteData = d;
		repeat (3) @(posedge clk);
		#1;
		ioWrite = w;
		ioRead = !w;
		repeat (5) @(posedge clk);
		#1;
		q = ioReadData;
		ioWrite = 1'b0;
		ioRead = 1'b0;
		ioWriteData = ~d;
		repeat (4) @(posedge clk);
	endtask : acc
endmodule : habr_host_model

// ### sim/habr_register_bank_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin errTotal++; $display("BAD %s %h %h", n, e, g); end end
module habr_register_bank_tb;
	import habr_pkg::*;
	logic clk, rst, ioWrite, ioRead, memAccessEnable, irq, linkEnable, porResponsePending;
	logic keystrokeAvailable, pollRequest, holdAddrZero;
	logic [9:0] ioAddr;
	logic [7:0] ioWriteData, ioReadData, displayLoadData, keystrokeCode, terminalId, displayControl;
	logic [6:0] memAddrHigh;
	logic [16:0] ev;
	logic [11:0] bufferWriteAddr;
	logic [15:0] bufferAddr;
	habr_mode_e mode;
	int errTotal = 0;
	int totalChecks = 0;
	logic [17:0] resetTab [9] = '{{10'h2d0, 8'h10}, {10'h2d1, 8'h00}, {10'h2d4, 8'h80}, {10'h2d7, 8'hce},
		{10'h2d8, 8'h00}, {10'h2d9, 8'h00}, {10'h2da, 8'h00}, {10'h2d5, 8'h00}, {10'h2db, 8'h00}};
	logic [23:0] modeTab [17] = '{24'h010081, 24'h010282, 24'h010384, 24'h010484, 24'h010584, 24'h010684,
		24'h010c90, 24'h010da0, 24'h010b40, 24'h010100, 24'h050181, 24'h050784, 24'h050884, 24'h050a00,
		24'h030984, 24'h030a88, 24'h030282};
	habr_register_bank u_habr_register_bank (.clk(clk), .rst(rst), .ioAddr(ioAddr), .ioWriteData(ioWriteData),
		.ioWrite(ioWrite), .ioRead(ioRead), .ioReadData(ioReadData), .memAddrHigh(memAddrHigh),
		.memAccessEnable(memAccessEnable), .irq(irq), .evKeyAck(ev[0]), .evStartOp(ev[1]), .evResetCmd(ev[2]),
		.evDisplayLoad(ev[3]), .displayLoadData(displayLoadData), .evPollAlarm(ev[4]), .evPollClickerOn(ev[5]),
		.evPollClickerOff(ev[6]), .evPollEnableOp(ev[7]), .evPollDisableOp(ev[8]), .evDiagReset(ev[9]),
		.evReadTermId(ev[10]), .evModifyBegin(ev[11]), .evModifyEnd(ev[12]), .evLoadIoAddr(ev[13]),
		.evPoll(ev[14]), .evPollAck(ev[15]), .evBufferWrite(ev[16]), .bufferWriteAddr(bufferWriteAddr),
		.bufferAddr(bufferAddr), .linkEnable(linkEnable), .mode(mode), .porResponsePending(porResponsePending),
		.keystrokeAvailable(keystrokeAvailable), .pollRequest(pollRequest), .holdAddrZero(holdAddrZero),
		.keystrokeCode(keystrokeCode), .terminalId(terminalId), .displayControl(displayControl));
	habr_host_model u_habr_host_model (.clk(clk), .ioReadData(ioReadData), .ioAddr(ioAddr),
		.ioWriteData(ioWriteData), .ioWrite(ioWrite), .ioRead(ioRead));
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_habr_host_model.acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_habr_host_model.acc(1'b0, a, 8'h00, q);
		`CHK($sformatf("reg %h", a), e, q)
	endtask : rd
	task automatic pulse(input int b);
		@(posedge clk) #1;
		ev = 17'h1 << b;
		@(posedge clk) #1;
		ev = 17'h0;
	endtask : pulse
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		$display("BAD watchdog 0 1");
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		ev = 17'h0;
		displayLoadData = 8'h48;
		bufferWriteAddr = 12'h9a5;
		bufferAddr = 16'h1234;
		memAddrHigh = 7'h67;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		foreach (resetTab[i]) rd(resetTab[i][17:8], resetTab[i][7:0]);
		pulse(3);
		rd(HABR_ADDR_INT_STATUS, 8'h10);
		wr(HABR_ADDR_LINK_ENABLE, 8'h00);
		`CHK("link", 1'b1, linkEnable)
		`CHK("por", 1'b1, porResponsePending)
		pulse(14);
		`CHK("por", 1'b0, porResponsePending)
		rd(HABR_ADDR_CONTROL, 8'h81);
		$display("test reset and link done");
		wr(HABR_ADDR_INT_STATUS, 8'hff);
		foreach (modeTab[i]) begin
			wr(HABR_ADDR_CONTROL, modeTab[i][23:16]);
			pulse(int'(modeTab[i][15:8]));
			rd(HABR_ADDR_INT_STATUS, modeTab[i][7:0]);
			`CHK("irq", modeTab[i][7], irq)
			wr(HABR_ADDR_INT_STATUS, 8'hff);
		end
		rd(HABR_ADDR_PRINTER, 8'hc0);
		wr(HABR_ADDR_PRINTER, 8'h40);
		rd(HABR_ADDR_PRINTER, 8'h80);
		wr(HABR_ADDR_CONTROL, 8'h01);
		pulse(11);
		pulse(12);
		rd(HABR_ADDR_INT_STATUS, 8'h90);
		wr(HABR_ADDR_INT_STATUS, 8'hff);
		$display("test status events done");
		wr(HABR_ADDR_CONTROL, 8'h81);
		pulse(0);
		rd(HABR_ADDR_INT_STATUS, 8'h01);
		`CHK("irq", 1'b0, irq)
		wr(HABR_ADDR_CONTROL, 8'h01);
		rd(HABR_ADDR_INT_STATUS, 8'h81);
		wr(HABR_ADDR_CONTROL, 8'h81);
		rd(HABR_ADDR_INT_STATUS, 8'h01);
		wr(HABR_ADDR_INT_STATUS, 8'h00);
		rd(HABR_ADDR_INT_STATUS, 8'h01);
		wr(HABR_ADDR_INT_STATUS, 8'h01);
		rd(HABR_ADDR_INT_STATUS, 8'h00);
		wr(HABR_ADDR_CONTROL, 8'h41);
		pulse(3);
		wr(HABR_ADDR_INT_STATUS, 8'hff);
		pulse(13);
		rd(HABR_ADDR_INT_STATUS, 8'h20);
		wr(HABR_ADDR_DISPLAY, 8'h00);
		rd(HABR_ADDR_DISPLAY, 8'h08);
		$display("test mask done");
		wr(HABR_ADDR_CURSOR_LOW, 8'hff);
		rd(HABR_ADDR_CURSOR_LOW, 8'h34);
		rd(HABR_ADDR_CURSOR_HIGH, 8'h12);
		wr(HABR_ADDR_KEYSTROKE, 8'ha5);
		`CHK("code", 8'ha5, keystrokeCode)
		wr(HABR_ADDR_TERMINAL, 8'h5a);
		`CHK("termid", 8'h5a, terminalId)
		rd(HABR_ADDR_TERMINAL, 8'h00);
		wr(HABR_ADDR_CONTROL, 8'h09);
		`CHK("key", 1'b1, keystrokeAvailable)
		pulse(15);
		`CHK("key", 1'b0, keystrokeAvailable)
		wr(HABR_ADDR_CONTROL, 8'h09);
		pulse(2);
		`CHK("key", 1'b0, keystrokeAvailable)
		wr(HABR_ADDR_CONTROL, 8'h13);
		`CHK("req", 1'b1, pollRequest)
		pulse(15);
		`CHK("req", 1'b0, pollRequest)
		wr(HABR_ADDR_CONTROL, 8'h45);
		`CHK("hold", 1'b1, holdAddrZero)
		`CHK("mode", PRINTER_MODE, mode)
		pulse(16);
		rd(HABR_ADDR_PAGE_HIGH, 8'h02);
		rd(HABR_ADDR_PAGE_LOW, 8'h00);
		wr(HABR_ADDR_PAGE_HIGH, 8'h02);
		rd(HABR_ADDR_PAGE_HIGH, 8'h00);
		`CHK("window", 1'b1, memAccessEnable)
		wr(HABR_ADDR_WINDOW, 8'hcf);
		`CHK("window", 1'b0, memAccessEnable)
		$display("test control and pages done");
		print_verdict();
	end
endmodule : habr_register_bank_tb
